// *** rsq_core_model.sv ***
`timescale 1ns/1ns
module rsq_core_model (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       core_reset,
  input  wire       irq_req,
  input  wire [3:0] irq_vector,
  input  wire [3:0] lat,
  input  wire       ret_cmd,
  output reg        core_vector_load,
  output reg        return_from_interrupt,
  output reg  [3:0] pc_r,
  output reg  [7:0] taken_r
);
  reg [3:0] wait_r;
  always @(posedge core_clk) begin
    core_vector_load <= 1'b0;
    return_from_interrupt <= ret_cmd;
    if (reset || core_reset) begin
      pc_r <= 4'h0;
      taken_r <= 8'h00;
      wait_r <= 4'h0;
    end else if (irq_req && !core_vector_load) begin
      // lat lets the core take its time, as a busy core would
      if (wait_r >= lat) begin
        core_vector_load <= 1'b1;
        pc_r <= irq_vector;
        taken_r <= taken_r + 8'h01;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule

// *** rsq_defines.vh ***
// Behaviour
// (RL1) Reset pin low over 50 ns resets
// (RL2) Reset loads registers; fetch starts at zero
// (RL3) Pin release starts delay; release after time-out
// (RL4) Time-out 1K fast fuse, 16K otherwise
// (RL5) Power-up holds reset through watchdog-clocked delay
// (RL6) Holding pin low lengthens power-on reset
// (RL7) Watchdog expiry resets only when enabled
// (RL8) Watchdog reset pulse lasts one clock
// (RL9) Delay starts at watchdog pulse end
// (RL10) Taking interrupt clears global enable
// (RL11) Return from interrupt sets global enable
// (RL12) Persistent condition flags only on new occurrence
// (RL13) Vector load clears serviced source flag
// (RL14) Writing one clears flag; zero keeps; the two lowest internal source flags have no write clear here
// (RL15) Disabled source flag stays pending
// (RL16) Pending served one by one, priority order
// (RL17) Level interrupt has no flag, live only
// (RL18) Mask bit 7 enables ext 1; 5..0 zero
// (RL19) Two sense bits pick edge or level
// (RL20) Pin activity requests even as output
// (RL21) External interrupt 1 vectors to 0x002
// (RL22) Thirteen vectors, lower address higher priority
// (RL23) Needs individual and global enable set
// (RL24) Mask bit 6 enables ext 0, vector 0x001
// (RL25) Ext 1 event sets flag; cleared two ways
// (RL26) Internal reset held then released synchronously
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

// register indices; byte address is four times the index
`define RSQ_IDX_EXT_MASK    8'h3B
`define RSQ_IDX_EXT_FLAGS   8'h3A
`define RSQ_IDX_CORE_STATUS 8'h3F
`define RSQ_IDX_MCU_CONTROL 8'h34
`define RSQ_IDX_SRC_FLAGS   8'h30
`define RSQ_IDX_RST_CAUSE   8'h31

// field positions
`define RSQ_BIT_EXT1        7
`define RSQ_BIT_EXT0        6
`define RSQ_BIT_GLOBAL_EN   7
`define RSQ_BIT_EXT1_SNS_HI 3
`define RSQ_BIT_EXT1_SNS_LO 2
`define RSQ_BIT_EXT0_SNS_HI 1
`define RSQ_BIT_EXT0_SNS_LO 0
`define RSQ_BIT_CAUSE_POR   0
`define RSQ_BIT_CAUSE_EXT   1
`define RSQ_BIT_CAUSE_WDT   2

// reset values
`define RSQ_RST_BYTE        8'h00

// sense-control encodings
`define RSQ_SENSE_LEVEL     2'h0
`define RSQ_SENSE_NONE      2'h1
`define RSQ_SENSE_FALL      2'h2
`define RSQ_SENSE_RISE      2'h3

// vectors
`define RSQ_VEC_RESET       4'h0
`define RSQ_VEC_EXT0        4'h1
`define RSQ_VEC_EXT1        4'h2
`define RSQ_VEC_FIRST_INT   4'h3

// timing
`define RSQ_CLK_PERIOD_NS   50
`define RSQ_EXT_RST_MIN_NS  50
`define RSQ_EXT_RST_CYC     ((`RSQ_EXT_RST_MIN_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_TOUT_FAST_OSC   1024
`define RSQ_TOUT_SLOW_OSC   16384

`endif

// *** rsq_props.sv ***
`timescale 1ns/1ns
module rsq_props (
  input wire core_clk,
  input wire reset,
  input wire reset_pin_n,
  input wire supply_ok,
  input wire wdt_expire,
  input wire wdt_enable,
  input wire core_vector_load,
  input wire return_from_interrupt,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire core_reset,
  input wire irq_req,
  input wire global_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rst; $fell(reset) |-> core_reset && avs_waitrequest; endproperty
  a_rst: assert property (p_rst) else $error("core not held after reset");
  property p_pin; !reset_pin_n |-> ##[1:2] core_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin low did not hold core");
  property p_sup; !supply_ok |-> ##[1:2] core_reset; endproperty
  a_sup: assert property (p_sup) else $error("low supply did not hold core");
  property p_wdon; wdt_expire && wdt_enable && !core_reset |-> ##[1:3] core_reset; endproperty
  a_wdon: assert property (p_wdon) else $error("enabled expiry ignored");
  // pin and supply must be quiet for two samples, else their own reset may be in flight
  property p_wdoff;
    !core_reset && wdt_expire && !wdt_enable && reset_pin_n && supply_ok
      && $past(reset_pin_n) && $past(supply_ok) |=> !core_reset;
  endproperty
  a_wdoff: assert property (p_wdoff) else $error("disabled expiry reset core");
  property p_entry; core_vector_load && irq_req |=> !irq_req && !global_enable; endproperty
  a_entry: assert property (p_entry) else $error("entry kept request or enable");
  property p_return_from_interrupt;
    return_from_interrupt && !core_vector_load && !core_reset |=> global_enable || core_reset;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return left enable clear");
  property p_gate; irq_req |-> global_enable || $past(global_enable); endproperty
  a_gate: assert property (p_gate) else $error("request without global enable");
  property p_held; core_reset |=> !irq_req && !global_enable; endproperty
  a_held: assert property (p_held) else $error("state alive during core reset");
  property p_bus; $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not one cycle");
endmodule
bind rsq_top rsq_props rsq_props_i (
  .core_clk              (core_clk),
  .reset                 (reset),
  .reset_pin_n           (reset_pin_n),
  .supply_ok             (supply_ok),
  .wdt_expire            (wdt_expire),
  .wdt_enable            (wdt_enable),
  .core_vector_load      (core_vector_load),
  .return_from_interrupt (return_from_interrupt),
  .avs_read              (avs_read),
  .avs_write             (avs_write),
  .avs_waitrequest       (avs_waitrequest),
  .core_reset            (core_reset),
  .irq_req               (irq_req),
  .global_enable         (global_enable)
);

// *** rsq_top.v ***
`timescale 1ns/1ns
`include "rsq_defines.vh"

module rsq_top #(
  parameter NUM_INT      = 10,
  parameter TOUT_FAST    = `RSQ_TOUT_FAST_OSC,
  parameter TOUT_SLOW    = `RSQ_TOUT_SLOW_OSC,
  parameter CNT_W        = 15
) (
  input  wire                core_clk,
  input  wire                reset,
  input  wire                reset_pin_n,
  input  wire                supply_ok,
  input  wire                fast_start_fuse,
  input  wire                wdt_osc,
  input  wire                wdt_expire,
  input  wire                wdt_enable,
  input  wire                ext_irq0_pin,
  input  wire                ext_irq1_pin,
  input  wire [NUM_INT-1:0]  irq_cond,
  input  wire [NUM_INT-1:0]  irq_enable,
  input  wire                core_vector_load,
  input  wire                return_from_interrupt,
  input  wire [9:0]          avs_address,
  input  wire                avs_read,
  input  wire                avs_write,
  input  wire [31:0]         avs_writedata,
  input  wire [3:0]          avs_byteenable,
  output wire [31:0]         avs_readdata,
  output wire                avs_waitrequest,
  output wire                core_reset,
  output wire                irq_req,
  output wire [3:0]          irq_vector,
  output wire                global_enable
);

  localparam NSRC = NUM_INT + 2;
  localparam [CNT_W-1:0] TOUT_FAST_C = TOUT_FAST[CNT_W-1:0];
  localparam [CNT_W-1:0] TOUT_SLOW_C = TOUT_SLOW[CNT_W-1:0];
  localparam integer     EXT_RST_I   = `RSQ_EXT_RST_CYC;
  localparam [3:0]       EXT_RST_C   = EXT_RST_I[3:0];

  // reset sequencer states
  localparam [1:0] ST_HOLD  = 2'h0;
  localparam [1:0] ST_COUNT = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  reg  [1:0]        rst_state_r;
  reg  [1:0]        rst_state_nxt;
  reg  [CNT_W-1:0]  tout_cnt_r;
  reg  [CNT_W-1:0]  tout_cnt_nxt;
  reg               core_reset_r;
  reg  [3:0]        pin_low_cnt_r;
  reg               pin_rst_r;
  reg               wdt_pulse_r;
  reg               osc_s1_r;
  reg               osc_s2_r;
  reg               osc_s3_r;
  reg  [2:0]        osc_vld_r;
  reg  [2:0]        cause_r;

  reg  [7:0]        ext_mask_r;
  reg  [3:0]        mcu_ctl_r;
  reg               global_en_r;
  reg  [NSRC-1:0]   pend_r;
  reg  [NSRC-1:0]   pend_nxt;
  reg               ext0_prev_r;
  reg               ext1_prev_r;
  reg  [NUM_INT-1:0] cond_prev_r;
  reg               irq_req_r;
  reg  [3:0]        irq_vector_r;

  reg               waitreq_r;
  reg  [7:0]        rdata_r;
  reg  [7:0]        rd_mux;

  wire              io_rst;
  wire              osc_tick;
  wire              src_active;
  wire [CNT_W-1:0]  tout_target;
  wire [7:0]        reg_idx;
  wire              wr_take;
  wire              wr_lane0;
  wire [7:0]        wbyte;
  wire [NSRC-1:0]   set_ev;
  wire [NSRC-1:0]   w1c;
  wire [NSRC-1:0]   svc_clr;
  wire [NSRC-1:0]   src_en;
  wire [NSRC-1:0]   live_req;
  wire [NSRC-1:0]   ready_req;
  wire              ext0_level;
  wire              ext1_level;
  wire              ext0_edge;
  wire              ext1_edge;
  wire [1:0]        ext0_sense;
  wire [1:0]        ext1_sense;
  reg  [3:0]        pick_vec;
  reg               pick_any;
  integer           i;

  // I/O registers except the reset cause go back to their initial values while the core is held
  assign io_rst = reset | core_reset_r; // RL2

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------

  // watchdog oscillator is a plain input here; a two-stage sync then edge detect
  always @(posedge core_clk) begin
    if (reset) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      osc_vld_r <= 3'h0;
    end else begin
      osc_s1_r <= wdt_osc;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      osc_vld_r <= {osc_vld_r[1:0], 1'b1};
    end
  end

  // no tick until the chain holds real samples, else a high oscillator at reset exit
  // would pass for an edge and cut the time-out short
  assign osc_tick = osc_s2_r & ~osc_s3_r & osc_vld_r[2]; // RL4

  // pin low for the minimum width counts as a reset; shorter blips are dropped.
  // the pin is sampled, so a stopped core clock cannot see it
  always @(posedge core_clk) begin
    if (reset) begin
      pin_low_cnt_r <= 4'h0;
      pin_rst_r     <= 1'b0;
    end else if (!reset_pin_n) begin
      if (pin_low_cnt_r < EXT_RST_C)
        pin_low_cnt_r <= pin_low_cnt_r + 4'h1;
      pin_rst_r <= (pin_low_cnt_r + 4'h1 >= EXT_RST_C); // RL1
    end else begin
      pin_low_cnt_r <= 4'h0;
      pin_rst_r     <= 1'b0;
    end
  end

  // one core-clock reset pulse per enabled expiry
  // the pulse blocks its own next cycle, so a held expiry still gives one clock
  always @(posedge core_clk) begin
    if (reset)
      wdt_pulse_r <= 1'b0;
    else
      wdt_pulse_r <= wdt_expire & wdt_enable & ~core_reset_r & ~wdt_pulse_r; // RL7 RL8
  end

  // pin held low keeps the sequencer parked, so an external hold stretches power-on
  assign src_active = pin_rst_r | ~supply_ok | wdt_pulse_r; // RL6

  assign tout_target = fast_start_fuse ? TOUT_FAST_C : TOUT_SLOW_C; // RL4

  // any source reasserting parks the sequencer and the count starts again from zero
  always @* begin
    rst_state_nxt = rst_state_r;
    tout_cnt_nxt  = tout_cnt_r;
    case (rst_state_r)
      ST_HOLD: begin
        tout_cnt_nxt = {CNT_W{1'b0}};
        if (!src_active)
          rst_state_nxt = ST_COUNT; // RL3 RL5 RL9
      end
      ST_COUNT: begin
        if (src_active) begin
          rst_state_nxt = ST_HOLD;
          tout_cnt_nxt  = {CNT_W{1'b0}};
        end else if (osc_tick) begin
          if (tout_cnt_r + 1'b1 >= tout_target)
            rst_state_nxt = ST_RUN; // RL3
          tout_cnt_nxt = tout_cnt_r + 1'b1;
        end
      end
      ST_RUN: begin
        if (src_active) begin
          rst_state_nxt = ST_HOLD;
          tout_cnt_nxt  = {CNT_W{1'b0}};
        end
      end
      default: begin
        rst_state_nxt = ST_HOLD;
        tout_cnt_nxt  = {CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      rst_state_r  <= ST_HOLD;
      tout_cnt_r   <= {CNT_W{1'b0}};
      core_reset_r <= 1'b1;
    end else begin
      rst_state_r  <= rst_state_nxt;
      tout_cnt_r   <= tout_cnt_nxt;
      core_reset_r <= (rst_state_nxt != ST_RUN); // RL26
    end
  end

  // reset cause: hardware sets, write-one clears, set wins
  always @(posedge core_clk) begin
    if (reset) begin
      cause_r <= 3'h0;
    end else begin
      cause_r[`RSQ_BIT_CAUSE_POR] <= ~supply_ok |
        (cause_r[`RSQ_BIT_CAUSE_POR] &
         ~(wr_take && reg_idx == `RSQ_IDX_RST_CAUSE && wbyte[`RSQ_BIT_CAUSE_POR]));
      cause_r[`RSQ_BIT_CAUSE_EXT] <= pin_rst_r |
        (cause_r[`RSQ_BIT_CAUSE_EXT] &
         ~(wr_take && reg_idx == `RSQ_IDX_RST_CAUSE && wbyte[`RSQ_BIT_CAUSE_EXT]));
      cause_r[`RSQ_BIT_CAUSE_WDT] <= wdt_pulse_r |
        (cause_r[`RSQ_BIT_CAUSE_WDT] &
         ~(wr_take && reg_idx == `RSQ_IDX_RST_CAUSE && wbyte[`RSQ_BIT_CAUSE_WDT]));
    end
  end

  // ---------------------------------------------------------------
  // register bus slave: one wait cycle, then the answer
  // ---------------------------------------------------------------

  assign reg_idx  = avs_address[9:2];
  assign wr_take  = avs_write & ~waitreq_r & wr_lane0;
  assign wr_lane0 = avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];

  always @(posedge core_clk) begin
    if (reset)
      waitreq_r <= 1'b1;
    else
      waitreq_r <= ~((avs_read | avs_write) & waitreq_r);
  end

  always @* begin
    case (reg_idx)
      `RSQ_IDX_EXT_MASK:    rd_mux = {ext_mask_r[7:6], 6'h00}; // RL18
      `RSQ_IDX_EXT_FLAGS:   rd_mux = {pend_r[1], pend_r[0], 6'h00};
      `RSQ_IDX_CORE_STATUS: rd_mux = {global_en_r, 7'h00};
      `RSQ_IDX_MCU_CONTROL: rd_mux = {4'h0, mcu_ctl_r};
      `RSQ_IDX_SRC_FLAGS:   rd_mux = pend_r[NSRC-1 -: 8];
      `RSQ_IDX_RST_CAUSE:   rd_mux = {5'h00, cause_r};
      default:              rd_mux = 8'h00;
    endcase
  end

  // read data are captured in the wait cycle and stand until the next read
  always @(posedge core_clk) begin
    if (reset)
      rdata_r <= 8'h00;
    else if (avs_read & waitreq_r)
      rdata_r <= rd_mux;
  end

  always @(posedge core_clk) begin
    if (io_rst) begin
      ext_mask_r <= `RSQ_RST_BYTE; // RL2
      mcu_ctl_r  <= 4'h0;
    end else if (wr_take) begin
      if (reg_idx == `RSQ_IDX_EXT_MASK)
        ext_mask_r <= {wbyte[7:6], 6'h00}; // RL18 RL24
      if (reg_idx == `RSQ_IDX_MCU_CONTROL)
        mcu_ctl_r <= wbyte[3:0]; // RL19
    end
  end

  // ---------------------------------------------------------------
  // interrupt sources
  // ---------------------------------------------------------------

  assign ext0_sense = {mcu_ctl_r[`RSQ_BIT_EXT0_SNS_HI], mcu_ctl_r[`RSQ_BIT_EXT0_SNS_LO]};
  assign ext1_sense = {mcu_ctl_r[`RSQ_BIT_EXT1_SNS_HI], mcu_ctl_r[`RSQ_BIT_EXT1_SNS_LO]};

  // pins are watched regardless of port direction, so a driven output still triggers
  always @(posedge core_clk) begin
    if (io_rst) begin
      ext0_prev_r <= 1'b1;
      ext1_prev_r <= 1'b1;
      cond_prev_r <= {NUM_INT{1'b0}};
    end else begin
      ext0_prev_r <= ext_irq0_pin; // RL20
      ext1_prev_r <= ext_irq1_pin; // RL20
      cond_prev_r <= irq_cond;
    end
  end

  assign ext0_level = (ext0_sense == `RSQ_SENSE_LEVEL) & ~ext_irq0_pin; // RL17
  assign ext1_level = (ext1_sense == `RSQ_SENSE_LEVEL) & ~ext_irq1_pin; // RL17
  assign ext0_edge  = ((ext0_sense == `RSQ_SENSE_FALL) & ext0_prev_r & ~ext_irq0_pin) |
                      ((ext0_sense == `RSQ_SENSE_RISE) & ~ext0_prev_r & ext_irq0_pin);
  assign ext1_edge  = ((ext1_sense == `RSQ_SENSE_FALL) & ext1_prev_r & ~ext_irq1_pin) |
                      ((ext1_sense == `RSQ_SENSE_RISE) & ~ext1_prev_r & ext_irq1_pin); // RL19

  // flags fire on the onset of a condition only, never on its level
  assign set_ev = {irq_cond & ~cond_prev_r, ext1_edge, ext0_edge}; // RL12 RL25

  assign w1c[1:0] = (wr_take && reg_idx == `RSQ_IDX_EXT_FLAGS) ?
                    {wbyte[`RSQ_BIT_EXT1], wbyte[`RSQ_BIT_EXT0]} : 2'h0; // RL14
  // the source flag byte clears the same top eight sources that it reads;
  // the two lowest have no software clear and leave only on vector entry
  assign w1c[NSRC-1:2] = (wr_take && reg_idx == `RSQ_IDX_SRC_FLAGS) ?
                         {wbyte, {(NUM_INT-8){1'b0}}} : {NUM_INT{1'b0}}; // RL14

  // source index k owns vector k+1
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_svc
      assign svc_clr[g] = core_vector_load & irq_req_r &
                          (irq_vector_r == g + 1); // RL13
    end
  endgenerate

  // a new event beats a clear in the same cycle
  always @* begin
    pend_nxt = (pend_r & ~w1c & ~svc_clr) | set_ev; // RL15 RL16 RL25
  end

  always @(posedge core_clk) begin
    if (io_rst)
      pend_r <= {NSRC{1'b0}};
    else
      pend_r <= pend_nxt;
  end

  assign src_en   = {irq_enable, ext_mask_r[`RSQ_BIT_EXT1], ext_mask_r[`RSQ_BIT_EXT0]}; // RL18 RL24
  assign live_req = {pend_r[NSRC-1:2], pend_r[1] | ext1_level, pend_r[0] | ext0_level};
  assign ready_req = live_req & src_en & {NSRC{global_en_r}}; // RL23

  // lowest index wins; vector zero belongs to reset
  always @* begin
    pick_vec = `RSQ_VEC_RESET;
    pick_any = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (ready_req[i]) begin
        pick_vec = i[3:0] + 4'h1; // RL16 RL21 RL22 RL24
        pick_any = 1'b1;
      end
    end
  end

  // global enable: taking an interrupt clears it and beats a return or a write
  // a status write landing in the entry cycle is lost; software must write again
  always @(posedge core_clk) begin
    if (io_rst)
      global_en_r <= 1'b0;
    else if (core_vector_load & irq_req_r)
      global_en_r <= 1'b0; // RL10
    else if (return_from_interrupt)
      global_en_r <= 1'b1; // RL11
    else if (wr_take && reg_idx == `RSQ_IDX_CORE_STATUS)
      global_en_r <= wbyte[`RSQ_BIT_GLOBAL_EN];
  end

  // request is withdrawn the cycle after acceptance, so only one is taken per entry
  always @(posedge core_clk) begin
    if (io_rst) begin
      irq_req_r    <= 1'b0;
      irq_vector_r <= `RSQ_VEC_RESET; // RL2 RL22
    end else if (core_vector_load & irq_req_r) begin
      irq_req_r    <= 1'b0; // RL16
      irq_vector_r <= irq_vector_r;
    end else begin
      irq_req_r    <= pick_any;
      irq_vector_r <= pick_any ? pick_vec : `RSQ_VEC_RESET;
    end
  end

  assign avs_readdata    = {24'h000000, rdata_r};
  assign avs_waitrequest = waitreq_r;
  assign core_reset      = core_reset_r;
  assign irq_req         = irq_req_r;
  assign irq_vector      = irq_vector_r;
  assign global_enable   = global_en_r;

endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  localparam TF = 4;
  localparam TS = 8;
  logic       core_clk = 0, reset = 1, reset_pin_n = 1, supply_ok = 1;
  logic       fast_start_fuse = 0, wdt_osc = 0, wdt_expire = 0, wdt_enable = 0;
  logic       ext_irq0_pin = 1, ext_irq1_pin = 0, avs_read = 0, avs_write = 0;
  logic [9:0] irq_cond = 0, irq_enable = 0, avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hF, lat = 0, irq_vector, pc_r;
  logic       ret_cmd = 0;
  wire        core_vector_load, return_from_interrupt, avs_waitrequest;
  wire        core_reset, irq_req, global_enable;
  wire [31:0] avs_readdata;
  wire [7:0]  taken_r;
  int         mismatches = 0, checks_done = 0, osc_n = 0, tk = 0;
  logic [7:0] r;
  rsq_top #(.TOUT_FAST(TF), .TOUT_SLOW(TS)) rsq_top_i (.*);
  rsq_core_model rsq_core_model_i (.*);
  always #25 core_clk = ~core_clk;
  // phase chosen so oscillator edges never meet a rising clock edge
  always #170 wdt_osc = ~wdt_osc;
  always @(posedge wdt_osc) osc_n = osc_n + 1;
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    @(posedge core_clk);
    avs_address <= {i, 2'b00};
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task automatic wait_rel;
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("mismatch at %0t: core never released", $time);
    end
  endtask
  task automatic wait_tk;
    int n;
    n = 0;
    while (taken_r !== tk[7:0] && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      $display("mismatch at %0t: interrupt never taken", $time);
    end
  endtask
  task automatic pin(input int w, input logic v);
    @(posedge core_clk);
    if (w == 1) ext_irq1_pin <= v;
    else ext_irq0_pin <= v;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic ret;
    @(posedge core_clk);
    ret_cmd <= 1'b1;
    @(posedge core_clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // k: 0 pin, 1 supply, 2 watchdog
  task automatic src(input int k, input logic f);
    @(posedge core_clk);
    fast_start_fuse <= f;
    if (k == 0) reset_pin_n <= 1'b0;
    else if (k == 1) begin
      supply_ok <= 1'b0;
      reset_pin_n <= 1'b0;
    end else begin
      wdt_enable <= 1'b1;
      wdt_expire <= 1'b1;
    end
    repeat (k == 2 ? 1 : 20) @(posedge core_clk);
    supply_ok <= 1'b1;
    wdt_expire <= 1'b0;
    wdt_enable <= 1'b0;
    // the pin outlasts supply-good, so the count must wait for its release
    if (k == 1) repeat (20) @(posedge core_clk);
    reset_pin_n <= 1'b1;
    osc_n = 0;
    repeat (3) @(posedge core_clk);
    chk(core_reset, 1'b1);
    wait_rel();
    chk(osc_n + 1 >= (f ? TF : TS) && osc_n <= (f ? TF : TS) + 1, 1'b1);
  endtask
  task automatic t_resets;
    wr(8'h20, 8'hFF);
    rd(8'h20, r);
    chk(r, 8'h00);
    wr(8'h3B, 8'hC0);
    src(0, 1'b0);
    rd(8'h3B, r);
    chk(r, 8'h00);
    src(1, 1'b1);
    src(2, 1'b0);
    @(posedge core_clk);
    wdt_expire <= 1'b1;
    @(posedge core_clk);
    wdt_expire <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(core_reset, 1'b0);
  endtask
  task automatic t_ext;
    wr(8'h34, 8'h0C);
    wr(8'h3B, 8'hFF);
    rd(8'h3B, r);
    chk(r, 8'hC0);
    wr(8'h3B, 8'h80);
    pin(1, 1'b1);
    rd(8'h3A, r);
    chk(r, 8'h80);
    wr(8'h3A, 8'h00);
    rd(8'h3A, r);
    chk(r, 8'h80);
    wr(8'h3A, 8'h80);
    rd(8'h3A, r);
    chk(r, 8'h00);
    pin(1, 1'b0);
    pin(1, 1'b1);
    wr(8'h3F, 8'h80);
    tk++;
    wait_tk();
    chk(pc_r, 4'h2);
    rd(8'h3F, r);
    chk(r, 8'h00);
    rd(8'h3A, r);
    chk(r, 8'h00);
    ret();
    rd(8'h3F, r);
    chk(r, 8'h80);
    wr(8'h34, 8'h08);
    pin(1, 1'b0);
    tk++;
    wait_tk();
    chk(pc_r, 4'h2);
    ret();
    wr(8'h34, 8'h00);
    tk++;
    wait_tk();
    rd(8'h3A, r);
    chk(r, 8'h00);
    pin(1, 1'b1);
    ret();
    wr(8'h34, 8'h04);
    wr(8'h3B, 8'h40);
    pin(0, 1'b0);
    tk++;
    wait_tk();
    chk(pc_r, 4'h1);
    pin(0, 1'b1);
    ret();
  endtask
  task automatic t_prio;
    @(posedge core_clk);
    irq_cond <= 10'h005;
    lat <= 4'h3;
    repeat (10) @(posedge core_clk);
    chk(taken_r, tk);
    rd(8'h30, r);
    chk(r, 8'h01);
    irq_enable <= 10'h005;
    tk++;
    wait_tk();
    chk(pc_r, 4'h3);
    ret();
    tk++;
    wait_tk();
    chk(pc_r, 4'h5);
    ret();
    repeat (10) @(posedge core_clk);
    chk(taken_r, tk);
    irq_cond <= 10'h085;
    rd(8'h30, r);
    chk(r, 8'h20);
    wr(8'h30, 8'h20);
    rd(8'h30, r);
    chk(r, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    wait_rel();
    chk(core_reset, 1'b0);
    t_resets();
    t_ext();
    t_prio();
    test_done();
  end
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule
